// ---- shared/scaling_router_pkg.sv ----
// Constants for the input scaling and output routing block.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package scaling_router_pkg;
    // Register byte offsets.
    localparam logic [5:0] OFF_INPUT_TYPE  = 6'h00;
    localparam logic [5:0] OFF_SCALE_HIGH  = 6'h04;
    localparam logic [5:0] OFF_SCALE_LOW   = 6'h08;
    localparam logic [5:0] OFF_DECIMALS    = 6'h0c;
    localparam logic [5:0] OFF_SHIFT_HIGH  = 6'h10;
    localparam logic [5:0] OFF_SHIFT_LOW   = 6'h14;
    localparam logic [5:0] OFF_ASSIGN      = 6'h18;
    localparam logic [5:0] OFF_CONTROL     = 6'h1c;
    localparam logic [5:0] OFF_PERIOD      = 6'h20;
    localparam logic [5:0] OFF_MANIP       = 6'h24;
    localparam logic [5:0] OFF_RAW_INPUT   = 6'h28;
    localparam logic [5:0] OFF_PROCESS     = 6'h2c;
    localparam logic [5:0] OFF_STATUS      = 6'h30;
    // Reset values, limits and the first analog input type.
    localparam logic [4:0]  INPUT_TYPE_MAX        = 5'h15;
    localparam logic [4:0]  THERMOCOUPLE_DEFAULT  = 5'h02;
    localparam logic [4:0]  FIRST_ANALOG_TYPE     = 5'h0e;
    localparam logic [15:0] SCALE_HIGH_RESET      = 16'h0064;
    localparam logic [15:0] SCALE_LOW_RESET       = 16'h0000;
    localparam logic [1:0]  DECIMALS_RESET        = 2'h0;
    localparam logic [7:0]  PERIOD_RESET_S        = 8'h14;
    localparam logic [6:0]  PERCENT_FULL          = 7'h64;
    // Output function codes.
    localparam logic [2:0] FN_HEAT  = 3'h0;
    localparam logic [2:0] FN_COOL  = 3'h1;
    localparam logic [2:0] FN_ALM1  = 3'h2;
    localparam logic [2:0] FN_ALM2  = 3'h3;
    localparam logic [2:0] FN_ALM3  = 3'h4;
    localparam logic [2:0] FN_LOOPB = 3'h5;
    localparam logic [2:0] FN_ERR1  = 3'h6;
    localparam logic [2:0] FN_ERR2  = 3'h7;
    // Per-destination permission masks, bit n allows function n.
    localparam logic [7:0] ALLOW_OUT1 = 8'h3f;
    localparam logic [7:0] ALLOW_OUT2 = 8'h3f;
    localparam logic [7:0] ALLOW_AUX1 = 8'hfc;
    // Field positions inside the assignment and control registers.
    localparam int ASSIGN_OUT1_LSB = 0;
    localparam int ASSIGN_OUT2_LSB = 4;
    localparam int ASSIGN_AUX1_LSB = 8;
    localparam int CTRL_DIRECT_BIT = 0;
    // Timing: one second time base.
    localparam int CLK_HZ       = 20000000;
    localparam int SECOND_S     = 1;
    localparam int SECOND_TICKS = CLK_HZ * SECOND_S;
    localparam int ADC_FULL     = 4095;
endpackage

// ---- core/process_input_scaling_output_router.sv ----
// Input conditioning and output routing stage of a process controller.
// Assumes a synchronous ADC sample, alarm and error levels from elsewhere,
// and a manipulated value in percent from the control loop.
// Notes on behaviour
// RULE1: Input type 0..21, default thermocouple code 2.
// RULE2: Scale only voltage or current inputs.
// RULE3: Range top maps to upper limit.
// RULE4: Decimal setting fixes fractional digits shown.
// RULE5: Defaults: upper 100, lower 0, decimals 0.
// RULE6: Temperature inputs shifted, never scaled.
// RULE7: Separate upper and lower shift settings.
// RULE8: Eight routable output functions generated.
// RULE9: Three outputs, forbidden selections refused.
// RULE10: Cool routed means heat and cool control.
// RULE11: Defaults: heat out1, alarm1 out2, alarm2 aux.
// RULE12: Direction selects reverse or direct action.
// RULE13: Pulse output repeats every control period.
// RULE14: Control period defaults to 20 seconds.
// RULE15: On time equals percent times period.
// RULE16: Short periods only with solid-state outputs.
// RULE17: Relay users weigh control against wear.
// RULE18: Scaled value interpolated between limits.
// RULE19: Period counter on second tick.
`timescale 1ns/10ps
module process_input_scaling_output_router #(
    parameter int TICK_CYCLES = scaling_router_pkg::SECOND_TICKS
) (
    input  wire logic        clk,             // 20 MHz clock.
    input  wire logic        rst_b,           // Async reset, active low.
    input  wire logic [5:0]  address,         // Avalon byte address.
    input  wire logic        read,            // Avalon read request.
    input  wire logic        write,           // Avalon write request.
    input  wire logic [31:0] writedata,       // Avalon write data.
    input  wire logic [3:0]  byteenable,      // Avalon byte lanes.
    output logic [31:0]      readdata,        // Avalon read data.
    output logic             waitrequest,     // Avalon stall.
    input  wire logic [11:0] rawInput,        // ADC sample, full scale 4095.
    input  wire logic [2:0]  alarmIn,         // Alarm 1..3 levels.
    input  wire logic        loopBreakAlarm,  // Loop break alarm level.
    input  wire logic        inputError,      // Input error level.
    input  wire logic        adcError,        // Converter error level.
    output logic             out1,            // Control output 1.
    output logic             out2,            // Control output 2.
    output logic             aux1,            // Auxiliary output 1.
    output logic             heatCoolMode,    // Heat and cool active.
    output logic             directAction,    // Direct action selected.
    output logic signed [15:0] processValue,  // Conditioned value.
    output logic [1:0]       decimalPlaces    // Fraction digits shown.
);
    import scaling_router_pkg::*;

    logic [4:0]         inputType;
    logic signed [15:0] scaleHigh, scaleLow, shiftHigh, shiftLow;
    logic [1:0]         decimalSetting;
    logic [2:0]         selOut1, selOut2, selAux1;
    logic               directSel;
    logic [7:0]         periodSec;
    logic [6:0]         manipulatedValue;
    logic               refusedFlag;
    logic               accessDone;
    logic [24:0]        tickCount;
    logic               secondTick;
    logic [7:0]         periodCount;
    logic [15:0]        onTicks, elapsedTicks;
    logic               pulseOn;
    logic [7:0]         functions;
    logic               isAnalog;

    // Each field write is checked against the destination's mask.
    function automatic logic allowed(input logic [7:0] mask,
                                     input logic [2:0] fn);
        allowed = mask[fn];
    endfunction

    // Linear interpolation by fraction num/den between lo and hi.
    function automatic logic signed [15:0] lerp(
        input logic signed [15:0] lo, input logic signed [15:0] hi,
        input logic [11:0] num, input int den);
        logic signed [31:0] span;
        span = 32'(hi) - 32'(lo);
        lerp = 16'(32'(lo) + (span * $signed({20'h0, num})) / den);
    endfunction

    // One-cycle wait state: every access answers on the second edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accessDone <= 1'b0;
        end else begin
            accessDone <= (read || write) && !accessDone;
        end
    end
    assign waitrequest = (read || write) && !accessDone;

    // Register writes; refused routing leaves the old selection in place.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // RULE1: default input type
            inputType      <= THERMOCOUPLE_DEFAULT;
            // RULE5: scaling defaults
            scaleHigh      <= SCALE_HIGH_RESET;
            scaleLow       <= SCALE_LOW_RESET;
            decimalSetting <= DECIMALS_RESET;
            shiftHigh      <= 16'h0000;
            shiftLow       <= 16'h0000;
            // RULE11: factory routing
            selOut1        <= FN_HEAT;
            selOut2        <= FN_ALM1;
            selAux1        <= FN_ALM2;
            directSel      <= 1'b0;
            // RULE14: default period
            periodSec      <= PERIOD_RESET_S;
            manipulatedValue <= 7'h00;
            refusedFlag    <= 1'b0;
        end else if (write && accessDone && byteenable[0]) begin
            case (address)
                OFF_INPUT_TYPE: begin
                    // RULE1: range check
                    if (writedata[4:0] <= INPUT_TYPE_MAX) begin
                        inputType <= writedata[4:0];
                    end else begin
                        refusedFlag <= 1'b1;
                    end
                end
                OFF_SCALE_HIGH: scaleHigh <= writedata[15:0];
                OFF_SCALE_LOW:  scaleLow  <= writedata[15:0];
                OFF_DECIMALS:   decimalSetting <= writedata[1:0];
                // RULE7: independent shifts
                OFF_SHIFT_HIGH: shiftHigh <= writedata[15:0];
                OFF_SHIFT_LOW:  shiftLow  <= writedata[15:0];
                OFF_ASSIGN: begin
                    // RULE9: refuse forbidden routing
                    if (allowed(ALLOW_OUT1, writedata[ASSIGN_OUT1_LSB +: 3])
                        && allowed(ALLOW_OUT2,
                                   writedata[ASSIGN_OUT2_LSB +: 3])
                        && allowed(ALLOW_AUX1,
                                   writedata[ASSIGN_AUX1_LSB +: 3])) begin
                        selOut1 <= writedata[ASSIGN_OUT1_LSB +: 3];
                        selOut2 <= writedata[ASSIGN_OUT2_LSB +: 3];
                        selAux1 <= writedata[ASSIGN_AUX1_LSB +: 3];
                    end else begin
                        refusedFlag <= 1'b1;
                    end
                end
                OFF_CONTROL: directSel <= writedata[CTRL_DIRECT_BIT];
                OFF_PERIOD: begin
                    if (writedata[7:0] != 8'h00) begin
                        periodSec <= writedata[7:0];
                    end
                end
                OFF_MANIP: begin
                    if (writedata[6:0] <= PERCENT_FULL) begin
                        manipulatedValue <= writedata[6:0];
                    end
                end
                OFF_STATUS: begin
                    // Write one clears the refusal flag.
                    if (writedata[0]) begin
                        refusedFlag <= 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    // Read data is registered on the first edge of the access, ready for the answering edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h0000_0000;
        end else if (read && !accessDone) begin
            case (address)
                OFF_INPUT_TYPE: readdata <= {27'h0, inputType};
                OFF_SCALE_HIGH: readdata <= {16'h0, scaleHigh};
                OFF_SCALE_LOW:  readdata <= {16'h0, scaleLow};
                OFF_DECIMALS:   readdata <= {30'h0, decimalSetting};
                OFF_SHIFT_HIGH: readdata <= {16'h0, shiftHigh};
                OFF_SHIFT_LOW:  readdata <= {16'h0, shiftLow};
                OFF_ASSIGN:     readdata <= {21'h0, selAux1, 1'b0,
                                             selOut2, 1'b0, selOut1};
                OFF_CONTROL:    readdata <= {31'h0, directSel};
                OFF_PERIOD:     readdata <= {24'h0, periodSec};
                OFF_MANIP:      readdata <= {25'h0, manipulatedValue};
                OFF_RAW_INPUT:  readdata <= {20'h0, rawInput};
                OFF_PROCESS:    readdata <= {16'h0, processValue};
                OFF_STATUS:     readdata <= {29'h0, pulseOn,
                                             heatCoolMode, refusedFlag};
                default:        readdata <= 32'h0000_0000;
            endcase
        end
    end

    // RULE2: analog types gate scaling
    assign isAnalog = inputType >= FIRST_ANALOG_TYPE;

    // Input conditioning, registered; one cycle of latency.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            processValue <= 16'h0000;
        end else if (isAnalog) begin
            // RULE3: endpoints map to limits
            // RULE18: linear interpolation
            processValue <= lerp(scaleLow, scaleHigh, rawInput, ADC_FULL);
        end else begin
            // RULE6: temperature shift only
            processValue <= 16'($signed({4'h0, rawInput})
                          + lerp(shiftLow, shiftHigh, rawInput, ADC_FULL));
        end
    end

    // RULE4: decimal places presented
    assign decimalPlaces = decimalSetting;

    // RULE19: one-second tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tickCount  <= 25'h0;
            secondTick <= 1'b0;
        end else if (tickCount == 25'(TICK_CYCLES - 1)) begin
            tickCount  <= 25'h0;
            secondTick <= 1'b1;
        end else begin
            tickCount  <= tickCount + 25'h1;
            secondTick <= 1'b0;
        end
    end

    // On time kept in percent-seconds, so no divider is needed.
    assign onTicks = 16'(periodSec * manipulatedValue);
    // RULE13: repeating period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            periodCount  <= 8'h00;
            elapsedTicks <= 16'h0000;
        end else if (write && accessDone && address == OFF_PERIOD) begin
            periodCount  <= 8'h00;
            elapsedTicks <= 16'h0000;
        end else if (secondTick) begin
            if (periodCount >= periodSec - 8'h01) begin
                periodCount  <= 8'h00;
                elapsedTicks <= 16'h0000;
            end else begin
                periodCount  <= periodCount + 8'h01;
                elapsedTicks <= elapsedTicks + 16'(PERCENT_FULL);
            end
        end
    end

    // RULE15: on for MV percent of period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pulseOn <= 1'b0;
        end else begin
            pulseOn <= elapsedTicks < onTicks;
        end
    end

    // RULE12: outside heat and cool mode, reverse drives heat and direct drives cool
    assign directAction = directSel;

    // RULE8: function vector
    always_comb begin
        functions          = 8'h00;
        functions[FN_HEAT] = pulseOn && !directSel;
        functions[FN_COOL] = pulseOn && directSel;
        functions[FN_ALM1] = alarmIn[0];
        functions[FN_ALM2] = alarmIn[1];
        functions[FN_ALM3] = alarmIn[2];
        functions[FN_LOOPB] = loopBreakAlarm;
        functions[FN_ERR1] = inputError;
        functions[FN_ERR2] = adcError;
        if (heatCoolMode) begin
            functions[FN_HEAT] = pulseOn;
            functions[FN_COOL] = pulseOn;
        end
    end

    // RULE10: cool routed selects heat and cool
    assign heatCoolMode = (selOut1 == FN_COOL) || (selOut2 == FN_COOL)
                       || (selAux1 == FN_COOL);

    // RULE9: routing to pins, registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out1 <= 1'b0;
            out2 <= 1'b0;
            aux1 <= 1'b0;
        end else begin
            out1 <= functions[selOut1];
            out2 <= functions[selOut2];
            aux1 <= functions[selAux1];
        end
    end

    // Assertions.
    routing_ok_a: assert property (@(posedge clk) disable iff (!rst_b)
        allowed(ALLOW_AUX1, selAux1)) // RULE9
        else $error("aux route holds forbidden function");
    type_range_a: assert property (@(posedge clk) disable iff (!rst_b)
        inputType <= INPUT_TYPE_MAX) // RULE1
        else $error("input type out of range");
    mode_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        (selOut2 == FN_COOL) |-> heatCoolMode) // RULE10
        else $error("cool routed but not heat cool");
    out_route_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 out1 == $past(functions[selOut1])) // RULE9
        else $error("output 1 not its routed function");
    zero_mv_a: assert property (@(posedge clk) disable iff (!rst_b)
        (manipulatedValue == 7'h00) [*2] |-> !pulseOn) // RULE15
        else $error("pulse on at zero MV");
    full_mv_a: assert property (@(posedge clk) disable iff (!rst_b)
        (manipulatedValue == PERCENT_FULL) [*2] |-> pulseOn) // RULE15
        else $error("pulse off at full MV");
    period_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
        periodCount < periodSec || $changed(periodSec)) // RULE13
        else $error("period counter past period");
    scale_top_a: assert property (@(posedge clk) disable iff (!rst_b)
        (isAnalog && rawInput == 12'hfff) ##1 $stable(scaleHigh)
        |-> processValue == scaleHigh) // RULE3
        else $error("top of range not upper limit");
endmodule

// ---- bench/plant_model.sv ----
// Sensor and actuator model for the scaling and routing block.
// Assumes the bench sets sample and fault levels right after a rising edge.
`timescale 1ns/10ps
module plant_model (
    input  wire logic        clk,            // System clock.
    input  wire logic [11:0] rawSet,         // Sample requested by bench.
    input  wire logic [5:0]  levelSet,       // Fault and alarm levels.
    input  wire logic        measure,        // Count load on-time while high.
    input  wire logic        out1,           // Heater load pin.
    output logic      [11:0] rawInput,       // Converter sample.
    output logic      [2:0]  alarmIn,        // Alarm levels.
    output logic             loopBreakAlarm, // Loop break level.
    output logic             inputError,     // Input error level.
    output logic             adcError,       // Converter error level.
    output logic      [15:0] onCount         // Cycles the load was on.
);
    // Sensor levels move only on a clock edge, as a sampled converter would.
    always_ff @(posedge clk) begin
        rawInput <= rawSet;
        {adcError, inputError, loopBreakAlarm, alarmIn} <= levelSet;
    end

    // load on-time count.
    // The load is a solid-state drive, so short periods cost no wear.
    always_ff @(posedge clk) begin
        if (!measure) begin
            onCount <= 16'h0000;
        end else if (out1) begin
            onCount <= onCount + 16'h0001;
        end
    end
endmodule

// ---- bench/process_input_scaling_output_router_test.sv ----
// Self-checking bench for the scaling and routing block.
// Assumes a ten-cycle time base; bus calls wait for the slave's answer.
`timescale 1ns/10ps
module process_input_scaling_output_router_test;
    import scaling_router_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, measure = 1'b0;
    logic [5:0] address = 6'h00, levelSet = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [3:0] byteenable = 4'hf;
    logic [11:0] rawSet = 12'h000, rawInput;
    logic [2:0] alarmIn;
    logic waitrequest, loopBreakAlarm, inputError, adcError, out1, out2, aux1;
    logic heatCoolMode, directAction;
    logic signed [15:0] processValue;
    logic [1:0] decimalPlaces;
    logic [15:0] onCount;
    int fails = 0, totalChecks = 0;

    process_input_scaling_output_router #(.TICK_CYCLES(10)) uut (.clk(clk),
        .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .rawInput(rawInput), .alarmIn(alarmIn),
        .loopBreakAlarm(loopBreakAlarm), .inputError(inputError),
        .adcError(adcError), .out1(out1), .out2(out2), .aux1(aux1),
        .heatCoolMode(heatCoolMode), .directAction(directAction),
        .processValue(processValue), .decimalPlaces(decimalPlaces));
    plant_model plant (.clk(clk), .rawSet(rawSet), .levelSet(levelSet),
        .measure(measure), .out1(out1), .rawInput(rawInput),
        .alarmIn(alarmIn), .loopBreakAlarm(loopBreakAlarm),
        .inputError(inputError), .adcError(adcError), .onCount(onCount));

    // 20 MHz clock.
    initial begin
        forever #25 clk = ~clk;
    end

    // Hold the request until a rising edge sees waitrequest low.
    // Values read right after the edge are those the edge sampled.
    task automatic busCycle(input logic [5:0] a, input logic isWr,
                            input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !isWr;
        write <= isWr;
        @(posedge clk);
        while (waitrequest) begin
            @(posedge clk);
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkReg(input logic [5:0] a, input logic [31:0] exp);
        busCycle(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic testDefaults;
        checkReg(OFF_INPUT_TYPE, 32'h0000_0002);
        checkReg(OFF_SCALE_HIGH, 32'h0000_0064);
        checkReg(OFF_SCALE_LOW, 32'h0000_0000);
        checkReg(OFF_DECIMALS, 32'h0000_0000);
        checkReg(OFF_ASSIGN, 32'h0000_0320);
        checkReg(OFF_PERIOD, 32'h0000_0014);
        check({30'h0, heatCoolMode, directAction}, 32'h0);
        $display("defaults done");
    endtask

    task automatic testRefusal;
        busCycle(OFF_INPUT_TYPE, 1'b1, 32'h0000_0016);
        checkReg(OFF_INPUT_TYPE, 32'h0000_0002);
        checkReg(OFF_STATUS, 32'h0000_0001);
        busCycle(OFF_STATUS, 1'b1, 32'h0000_0001);
        busCycle(OFF_ASSIGN, 1'b1, 32'h0000_0005);
        checkReg(OFF_ASSIGN, 32'h0000_0320);
        busCycle(OFF_INPUT_TYPE, 1'b1, 32'h0000_0015);
        checkReg(OFF_INPUT_TYPE, 32'h0000_0015);
        checkReg(6'h3c, 32'h0000_0000);
        $display("refusal done");
    endtask

    task automatic testScaling;
        busCycle(OFF_INPUT_TYPE, 1'b1, 32'h0000_0011);
        busCycle(OFF_SCALE_HIGH, 1'b1, 32'h0000_03b6);
        busCycle(OFF_SCALE_LOW, 1'b1, 32'h0000_0064);
        busCycle(OFF_DECIMALS, 1'b1, 32'h0000_0001);
        rawSet <= 12'hfff;
        settle(4);
        check({16'h0, processValue}, 32'h0000_03b6);
        rawSet <= 12'h000;
        settle(4);
        check({16'h0, processValue}, 32'h0000_0064);
        check({30'h0, decimalPlaces}, 32'h0000_0001);
        $display("scaling done");
    endtask

    task automatic testShift;
        busCycle(OFF_INPUT_TYPE, 1'b1, {27'h0, THERMOCOUPLE_DEFAULT});
        settle(4);
        check({16'h0, processValue}, 32'h0000_0000);
        busCycle(OFF_SHIFT_LOW, 1'b1, 32'h0000_0005);
        busCycle(OFF_SHIFT_HIGH, 1'b1, 32'h0000_0005);
        settle(4);
        check({16'h0, processValue}, 32'h0000_0005);
        busCycle(OFF_SHIFT_HIGH, 1'b1, 32'h0000_0000);
        settle(4);
        check({16'h0, processValue}, 32'h0000_0005);
        rawSet <= 12'hfff;
        settle(4);
        check({16'h0, processValue}, 32'h0000_0fff);
        $display("shift done");
    endtask

    task automatic testRouting;
        busCycle(OFF_ASSIGN, 1'b1, 32'h0000_0745);
        levelSet <= 6'h08;
        settle(4);
        check({29'h0, out1, out2, aux1}, 32'h0000_0004);
        levelSet <= 6'h04;
        settle(4);
        check({29'h0, out1, out2, aux1}, 32'h0000_0002);
        levelSet <= 6'h20;
        settle(4);
        check({29'h0, out1, out2, aux1}, 32'h0000_0001);
        levelSet <= 6'h00;
        busCycle(OFF_ASSIGN, 1'b1, 32'h0000_0715);
        busCycle(OFF_CONTROL, 1'b1, 32'h0000_0001);
        check({31'h0, heatCoolMode}, 32'h0000_0001);
        check({31'h0, directAction}, 32'h0000_0001);
        busCycle(OFF_CONTROL, 1'b1, 32'h0000_0000);
        check({31'h0, directAction}, 32'h0000_0000);
        $display("routing done");
    endtask

    // Measure over one whole period once the new setting has taken hold.
    task automatic pulseCase(input logic [31:0] mv, input logic [15:0] exp);
        busCycle(OFF_MANIP, 1'b1, mv);
        settle(120);
        measure <= 1'b1;
        settle(40);
        measure <= 1'b0;
        settle(1);
        check({16'h0, onCount}, {16'h0, exp});
    endtask

    task automatic testPulse;
        busCycle(OFF_ASSIGN, 1'b1, 32'h0000_0320);
        busCycle(OFF_PERIOD, 1'b1, 32'h0000_0004);
        pulseCase(32'h0000_0032, 16'h0014);
        pulseCase(32'h0000_0019, 16'h000a);
        pulseCase(32'h0000_0065, 16'h000a);
        pulseCase(32'h0000_0064, 16'h0028);
        busCycle(OFF_PERIOD, 1'b1, 32'h0000_0000);
        checkReg(OFF_PERIOD, 32'h0000_0004);
        $display("pulse done");
    endtask

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Tests need about 800 cycles; cut a hang well after that.
    initial begin
        repeat (8000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial begin
        settle(12);
        rst_b <= 1'b1;
        settle(1);
        testDefaults();
        testRefusal();
        testScaling();
        testShift();
        testRouting();
        testPulse();
        give_verdict();
    end
endmodule
